// file: hw/crxf_cnt_if.sv
// crxf_cnt_if: error counters in, bus status codes out
// assumes: driven by the top, answered by the status coder
`timescale 1ns/1ps
`default_nettype none

interface crxf_cnt_if;
   logic [8:0]          tec;
   logic [7:0]          rec;
   crxf_pkg::crxf_stat_t rx_code;
   crxf_pkg::crxf_stat_t tx_code;

   modport enc (input tec, input rec, output rx_code, output tx_code);
   modport top (output tec, output rec, input rx_code, input tx_code);
endinterface

`default_nettype wire

// file: hw/crxf_pkg.sv
// crxf_pkg: constants and types of the receive flag / interrupt enable block
// assumes: one 25 MHz clock, byte-wide register port
package crxf_pkg;

   // register port
   localparam int         ADDR_W     = 4;
   localparam logic [3:0] FLAGS_ADDR = 4'h0;
   localparam logic [3:0] IEN_ADDR   = 4'h1;
   localparam logic [7:0] RD_ZERO    = 8'h00;

   // bit positions, shared by flag and enable register
   localparam int B_WAKE    = 7;
   localparam int B_SCF     = 6;
   localparam int B_RLVL    = 4;
   localparam int B_TLVL    = 2;
   localparam int B_OVR     = 1;
   localparam int B_RX_FULL = 0;

   // error counter thresholds
   localparam logic [8:0] TEC_BOFF_LIM = 9'h0ff;
   localparam logic [8:0] TEC_ERR_LIM  = 9'h07f;
   localparam logic [8:0] TEC_WRN_LIM  = 9'h060;
   localparam logic [7:0] REC_ERR_LIM  = 8'h7f;
   localparam logic [7:0] REC_WRN_LIM  = 8'h60;

   // bus status coding
   typedef enum logic [1:0] {
      ST_OK   = 2'b00,
      ST_WRN  = 2'b01,
      ST_ERR  = 2'b10,
      ST_BOFF = 2'b11
   } crxf_stat_t;

   // status change sensitivity
   typedef enum logic [1:0] {
      LV_NONE = 2'b00,
      LV_BOFF = 2'b01,
      LV_ERR  = 2'b10,
      LV_ALL  = 2'b11
   } crxf_lvl_t;

   // whole state of the top module
   typedef struct packed {
      logic       wake;
      logic       scf;
      crxf_stat_t rst;
      crxf_stat_t tst;
      logic       ovr;
      logic       rx_full;
      logic       wake_ie;
      logic       scf_ie;
      crxf_lvl_t  rlvl;
      crxf_lvl_t  tlvl;
      logic       ovr_ie;
      logic       rx_full_ie;
      logic [7:0] rdata;
   } crxf_state_t;

   localparam crxf_state_t STATE_RST = '{
      wake: 1'b0, scf: 1'b0, rst: ST_OK, tst: ST_OK, ovr: 1'b0, rx_full: 1'b0,
      wake_ie: 1'b0, scf_ie: 1'b0, rlvl: LV_NONE, tlvl: LV_NONE,
      ovr_ie: 1'b0, rx_full_ie: 1'b0, rdata: 8'h00
   };

endpackage

// file: hw/crxf_state_code.sv
// crxf_state_code: maps error counters onto receiver and transmitter status
// assumes: counters are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module crxf_state_code (
   // counters and codes
   crxf_cnt_if.enc cnt
);

   always_comb begin
      // bus-off overrides the receiver coding as well
      if (cnt.tec > crxf_pkg::TEC_BOFF_LIM) begin
         cnt.rx_code = crxf_pkg::ST_BOFF;
      end else if (cnt.rec > crxf_pkg::REC_ERR_LIM) begin
         cnt.rx_code = crxf_pkg::ST_ERR;
      end else if (cnt.rec > crxf_pkg::REC_WRN_LIM) begin
         cnt.rx_code = crxf_pkg::ST_WRN;
      end else begin
         cnt.rx_code = crxf_pkg::ST_OK;
      end
      if (cnt.tec > crxf_pkg::TEC_BOFF_LIM) begin
         cnt.tx_code = crxf_pkg::ST_BOFF;
      end else if (cnt.tec > crxf_pkg::TEC_ERR_LIM) begin
         cnt.tx_code = crxf_pkg::ST_ERR;
      end else if (cnt.tec > crxf_pkg::TEC_WRN_LIM) begin
         cnt.tx_code = crxf_pkg::ST_WRN;
      end else begin
         cnt.tx_code = crxf_pkg::ST_OK;
      end
   end

endmodule // crxf_state_code

`default_nettype wire

// file: hw/crxf_top.sv
// crxf_top: receive flags, receive interrupt enables and interrupt outputs
// assumes: counters, events and init handshake come from logic on ref_clk
// Operation
// - overrun sets flag; pending error request while set
// - rx full set on good message shift
// - rx full blocks shift; receive request pending
// - tec above 255 gives receiver bus-off
// - status fields keep tracking during init
// - enables held reset in init, writable only with init request and acknowledge both low
// - sensitivity fields survive init mode
// - receiver sensitivity gates status change flag
// - transmitter sensitivity gates status change flag
// - status fields update only without pending change
// - wake enable gates wake request
// - change enable gates error request
// - overrun enable gates error request
// - rx full enable gates receive request
// - write one clears flags; status read-only
// - receiver status coding from receive counter
// - counter status change sets change flag
`timescale 1ns/1ps
`default_nettype none

module crxf_top (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // register port
   input  wire logic [crxf_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [7:0]                   reg_rdata,
   // init handshake
   input  wire logic                         init_request,
   input  wire logic                         init_acknowledge,
   // protocol engine
   input  wire logic [8:0]                   tec,
   input  wire logic [7:0]                   rec,
   input  wire logic                         overrun_event,
   input  wire logic                         wake_event,
   input  wire logic                         wake_on_bus_enable,
   input  wire logic                         rx_fifo_not_empty,
   output logic                              rx_shift,
   // status and interrupts
   output logic [1:0]                        receiver_state,
   output logic [1:0]                        transmitter_state,
   output logic                              irq_err,
   output logic                              irq_rx,
   output logic                              irq_wake
);

   crxf_pkg::crxf_state_t r_reg;
   crxf_pkg::crxf_state_t r_next;
   logic                  in_init;
   logic                  wr_ok;
   logic                  wr_flags;
   logic                  wr_ien;

   crxf_cnt_if cnt ();

   assign cnt.tec = tec;
   assign cnt.rec = rec;

   crxf_state_code u_code (
      .cnt (cnt.enc)
   );

   // does a status move old -> new qualify at this sensitivity
   function automatic logic chg_hit(crxf_pkg::crxf_lvl_t  lvl,
                                    crxf_pkg::crxf_stat_t old_s,
                                    crxf_pkg::crxf_stat_t new_s);
      logic moved;
      moved = (old_s != new_s);
      unique case (lvl)
         crxf_pkg::LV_NONE: chg_hit = 1'b0;
         crxf_pkg::LV_BOFF: chg_hit = moved &&
            ((old_s == crxf_pkg::ST_BOFF) || (new_s == crxf_pkg::ST_BOFF));
         crxf_pkg::LV_ERR:  chg_hit = moved && (old_s[1] || new_s[1]);
         crxf_pkg::LV_ALL:  chg_hit = moved;
      endcase
   endfunction

   assign in_init  = init_request & init_acknowledge;
   assign wr_ok    = ~init_request & ~init_acknowledge;
   assign wr_flags = reg_wr & wr_ok & (reg_addr == crxf_pkg::FLAGS_ADDR);
   assign wr_ien   = reg_wr & wr_ok & (reg_addr == crxf_pkg::IEN_ADDR);

   // foreground buffer takes the next entry only once released
   assign rx_shift = ~r_reg.rx_full & rx_fifo_not_empty & ~in_init;

   always_comb begin
      r_next = r_reg;

      // write one clears, zero ignored
      if (wr_flags) begin
         if (reg_wdata[crxf_pkg::B_WAKE]) begin
            r_next.wake = 1'b0;
         end
         if (reg_wdata[crxf_pkg::B_SCF]) begin
            r_next.scf = 1'b0;
         end
         if (reg_wdata[crxf_pkg::B_OVR]) begin
            r_next.ovr = 1'b0;
         end
         if (reg_wdata[crxf_pkg::B_RX_FULL]) begin
            r_next.rx_full = 1'b0;
         end
      end

      // status fields follow counters unless a change is pending
      if (!r_reg.scf) begin
         r_next.rst = cnt.rx_code;
         r_next.tst = cnt.tx_code;
         // leaving bus-off puts the receiver straight back to ok
         if (r_reg.tst == crxf_pkg::ST_BOFF && cnt.tx_code != crxf_pkg::ST_BOFF) begin
            r_next.rst = crxf_pkg::ST_OK;
         end
         if (!in_init &&
             (chg_hit(r_reg.rlvl, r_reg.rst, r_next.rst) ||
              chg_hit(r_reg.tlvl, r_reg.tst, cnt.tx_code))) begin
            r_next.scf = 1'b1;
         end
      end

      // sets win over same-cycle clears
      if (wake_event && wake_on_bus_enable) begin
         r_next.wake = 1'b1;
      end
      if (overrun_event) begin
         r_next.ovr = 1'b1;
      end
      if (rx_shift) begin
         r_next.rx_full = 1'b1;
      end

      if (wr_ien) begin
         r_next.wake_ie = reg_wdata[crxf_pkg::B_WAKE];
         r_next.scf_ie  = reg_wdata[crxf_pkg::B_SCF];
         r_next.rlvl    = crxf_pkg::crxf_lvl_t'(reg_wdata[crxf_pkg::B_RLVL +: 2]);
         r_next.tlvl    = crxf_pkg::crxf_lvl_t'(reg_wdata[crxf_pkg::B_TLVL +: 2]);
         r_next.ovr_ie  = reg_wdata[crxf_pkg::B_OVR];
         r_next.rx_full_ie = reg_wdata[crxf_pkg::B_RX_FULL];
      end

      // init mode holds all but status, sensitivity and read data at reset
      if (in_init) begin
         r_next.wake    = crxf_pkg::STATE_RST.wake;
         r_next.scf     = crxf_pkg::STATE_RST.scf;
         r_next.ovr     = crxf_pkg::STATE_RST.ovr;
         r_next.rx_full = crxf_pkg::STATE_RST.rx_full;
         r_next.wake_ie = crxf_pkg::STATE_RST.wake_ie;
         r_next.scf_ie  = crxf_pkg::STATE_RST.scf_ie;
         r_next.ovr_ie  = crxf_pkg::STATE_RST.ovr_ie;
         r_next.rx_full_ie = crxf_pkg::STATE_RST.rx_full_ie;
      end

      // read data in the cycle after the strobe
      r_next.rdata = crxf_pkg::RD_ZERO;
      if (reg_rd) begin
         if (reg_addr == crxf_pkg::FLAGS_ADDR) begin
            r_next.rdata = {r_reg.wake, r_reg.scf, r_reg.rst, r_reg.tst,
                            r_reg.ovr, r_reg.rx_full};
         end else if (reg_addr == crxf_pkg::IEN_ADDR) begin
            r_next.rdata = {r_reg.wake_ie, r_reg.scf_ie, r_reg.rlvl,
                            r_reg.tlvl, r_reg.ovr_ie, r_reg.rx_full_ie};
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_reg <= crxf_pkg::STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata         = r_reg.rdata;
   assign receiver_state    = r_reg.rst;
   assign transmitter_state = r_reg.tst;
   // one error request for overrun and status change
   assign irq_err  = (r_reg.ovr & r_reg.ovr_ie) |
                     (r_reg.scf & r_reg.scf_ie);
   assign irq_rx   = r_reg.rx_full & r_reg.rx_full_ie;
   assign irq_wake = r_reg.wake & r_reg.wake_ie;

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_ovr_sets: assert property (
      overrun_event && !in_init |=> r_reg.ovr && (!r_reg.ovr_ie || irq_err))
      else $error("overrun event did not set flag or error request");

   chk_rx_shift_set: assert property (
      rx_shift |=> r_reg.rx_full && !rx_shift)
      else $error("shift did not set rx full");

   chk_rx_block: assert property (
      r_reg.rx_full |-> !rx_shift)
      else $error("shift while rx full set");

   chk_rx_irq: assert property (
      $rose(r_reg.rx_full) && r_reg.rx_full_ie |-> irq_rx)
      else $error("receive request missing");

   chk_busoff_code: assert property (
      tec > crxf_pkg::TEC_BOFF_LIM && !r_reg.scf |=>
         receiver_state == crxf_pkg::ST_BOFF &&
         transmitter_state == crxf_pkg::ST_BOFF)
      else $error("bus-off not reported");

   chk_init_hold: assert property (
      in_init |=> !r_reg.wake_ie && !r_reg.scf_ie && !r_reg.ovr_ie &&
                  !r_reg.rx_full_ie && !irq_err && !irq_rx && !irq_wake)
      else $error("enables not held in init");

   chk_lvl_keep: assert property (
      in_init |=> $stable(r_reg.rlvl) && $stable(r_reg.tlvl))
      else $error("sensitivity changed in init");

   chk_stat_freeze: assert property (
      r_reg.scf |=> $stable(receiver_state) && $stable(transmitter_state))
      else $error("status moved while change pending");

   chk_no_sens: assert property (
      !r_reg.scf && r_reg.rlvl == crxf_pkg::LV_NONE &&
      r_reg.tlvl == crxf_pkg::LV_NONE |=> !r_reg.scf)
      else $error("change flag set with no sensitivity");

   chk_wake_irq: assert property (
      wake_event && wake_on_bus_enable && r_reg.wake_ie && !in_init
         |=> irq_wake)
      else $error("wake request missing");

   chk_clear_w1: assert property (
      wr_flags && reg_wdata[crxf_pkg::B_OVR] && !overrun_event |=> !r_reg.ovr)
      else $error("write one did not clear overrun");

   chk_ovr_hold: assert property (
      r_reg.ovr && !in_init && !(wr_flags && reg_wdata[crxf_pkg::B_OVR]) |=> r_reg.ovr)
      else $error("overrun flag dropped without clear");

   chk_rx_full_hold: assert property (
      r_reg.rx_full && !in_init && !(wr_flags && reg_wdata[crxf_pkg::B_RX_FULL])
         |=> r_reg.rx_full)
      else $error("rx full dropped without clear");

   chk_shift_init: assert property (
      in_init |-> !rx_shift)
      else $error("shift during init mode");

   chk_boff_exit: assert property (
      !r_reg.scf && r_reg.tst == crxf_pkg::ST_BOFF && tec <= crxf_pkg::TEC_BOFF_LIM
         |=> receiver_state == crxf_pkg::ST_OK)
      else $error("receiver not ok after bus-off exit");

   chk_init_flags: assert property (
      in_init |=> !r_reg.wake && !r_reg.scf && !r_reg.ovr && !r_reg.rx_full)
      else $error("flags not held in init");

   chk_stat_track: assert property (
      in_init && !r_reg.scf && tec <= crxf_pkg::TEC_WRN_LIM
         |=> transmitter_state == crxf_pkg::ST_OK)
      else $error("status stopped tracking in init");

   chk_ien_write: assert property (
      wr_ien |=> r_reg.wake_ie == $past(reg_wdata[crxf_pkg::B_WAKE]) &&
                 r_reg.scf_ie == $past(reg_wdata[crxf_pkg::B_SCF]) &&
                 r_reg.rx_full_ie == $past(reg_wdata[crxf_pkg::B_RX_FULL]))
      else $error("enable write not taken");

   chk_rx_err_lvl: assert property (
      !r_reg.scf && !in_init && r_reg.rlvl == crxf_pkg::LV_ERR &&
      r_reg.rst == crxf_pkg::ST_WRN && rec > crxf_pkg::REC_ERR_LIM |=> r_reg.scf)
      else $error("error level move not flagged");

   chk_tx_boff_only: assert property (
      !r_reg.scf && r_reg.rlvl == crxf_pkg::LV_NONE && r_reg.tlvl == crxf_pkg::LV_BOFF &&
      r_reg.tst != crxf_pkg::ST_BOFF && tec <= crxf_pkg::TEC_BOFF_LIM |=> !r_reg.scf)
      else $error("change flag set below bus-off level");

   chk_wake_gate: assert property (
      wake_event && !wake_on_bus_enable && !r_reg.wake |=> !r_reg.wake)
      else $error("wake flag set without bus wake enable");

   chk_rd_idle: assert property (
      !reg_rd |=> reg_rdata == crxf_pkg::RD_ZERO)
      else $error("read data outside read cycle");

   chk_scf_set: assert property (
      !r_reg.scf && !in_init && r_reg.rlvl == crxf_pkg::LV_ALL &&
      r_reg.rst == crxf_pkg::ST_OK && rec > crxf_pkg::REC_WRN_LIM |=> r_reg.scf)
      else $error("status move not flagged");

endmodule // crxf_top

`default_nettype wire

// file: testbench/testbench.sv
// testbench: self-checking bench of the receive flag and enable block
// assumes: hw package, interface and modules compiled before this file
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        init_request = 1'b0;
   logic        init_acknowledge = 1'b0;
   logic [8:0]  tec = 9'h000;
   logic [7:0]  rec = 8'h00;
   logic        overrun_event = 1'b0;
   logic        wake_event = 1'b0;
   logic        wake_on_bus_enable = 1'b0;
   logic        rx_fifo_not_empty = 1'b0;
   logic        rx_shift, irq_err, irq_rx, irq_wake;
   logic [1:0]  receiver_state, transmitter_state;
   int          num_errors = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [7:0]  exp_q[$];
   logic        rd_pend = 1'b0;
   logic [31:0] seed = 32'h0000_4a58;
   int          need[4] = '{3, 2, 1, 1};
   logic [8:0]  tt[4] = '{9'h061, 9'h0c8, 9'h12c, 9'h000};
   logic [7:0]  rr[4] = '{8'h61, 8'hc8, 8'hc8, 8'h00};

   crxf_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_request(init_request),
      .init_acknowledge(init_acknowledge), .tec(tec), .rec(rec), .overrun_event(overrun_event),
      .wake_event(wake_event), .wake_on_bus_enable(wake_on_bus_enable),
      .rx_fifo_not_empty(rx_fifo_not_empty), .rx_shift(rx_shift),
      .receiver_state(receiver_state), .transmitter_state(transmitter_state),
      .irq_err(irq_err), .irq_rx(irq_rx), .irq_wake(irq_wake));

   always #20 ref_clk = ~ref_clk;

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   // expected status codes, receiver then transmitter
   function automatic logic [3:0] codes(input logic [8:0] t, input logic [7:0] r);
      logic [1:0] rc;
      logic [1:0] tc;
      rc = (r <= 8'h60) ? 2'b00 : (r <= 8'h7f) ? 2'b01 : 2'b10;
      tc = (t <= 9'h060) ? 2'b00 : (t <= 9'h07f) ? 2'b01 : (t <= 9'h0ff) ? 2'b10 : 2'b11;
      if (t > 9'h0ff) begin
         rc = 2'b11;
      end
      return {rc, tc};
   endfunction

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         num_errors++;
         $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, want);
      end
   endtask

   task automatic chk1(input logic seen, input logic want);
      check({7'h00, seen}, {7'h00, want});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
   endtask

   task automatic ev(input logic o, input logic w);
      @(posedge ref_clk);
      overrun_event <= o;
      wake_event <= w;
      @(posedge ref_clk);
      overrun_event <= 1'b0;
      wake_event <= 1'b0;
      #1;
   endtask

   task automatic cnt(input logic [8:0] t, input logic [7:0] r);
      @(posedge ref_clk);
      tec <= t;
      rec <= r;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (rd_pend) begin
         check(reg_rdata, exp_q.pop_front());
      end
      rd_pend <= reg_rd;
      if (cycles == 6000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      logic [7:0] v;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(4'h0, 8'h00);
      rd(4'h5, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         wr(4'h1, v);
         wr(4'h9, ~v);
         rd(4'h1, v);
      end
      $display("test registers done");
      wr(4'h1, 8'h02);
      ev(1'b1, 1'b0);
      chk1(irq_err, 1'b1);
      wr(4'h0, 8'hfd);
      rd(4'h0, 8'h02);
      wr(4'h1, 8'h00);
      chk1(irq_err, 1'b0);
      wr(4'h0, 8'h02);
      rd(4'h0, 8'h00);
      wr(4'h1, 8'h80);
      ev(1'b0, 1'b1);
      chk1(irq_wake, 1'b0);
      @(posedge ref_clk);
      wake_on_bus_enable <= 1'b1;
      ev(1'b0, 1'b1);
      chk1(irq_wake, 1'b1);
      rd(4'h0, 8'h80);
      wr(4'h0, 8'h80);
      chk1(irq_wake, 1'b0);
      $display("test overrun and wake done");
      wr(4'h1, 8'h01);
      @(posedge ref_clk);
      rx_fifo_not_empty <= 1'b1;
      #1;
      chk1(rx_shift, 1'b1);
      repeat (3) @(posedge ref_clk);
      #1;
      chk1(rx_shift, 1'b0);
      chk1(irq_rx, 1'b1);
      wr(4'h0, 8'h00);
      // buffer may be read only now that rx full shows set
      rd(4'h0, 8'h01);
      wr(4'h0, 8'h01);
      chk1(rx_shift, 1'b1);
      @(posedge ref_clk);
      rx_fifo_not_empty <= 1'b0;
      #1;
      chk1(irq_rx, 1'b1);
      wr(4'h1, 8'h00);
      chk1(irq_rx, 1'b0);
      wr(4'h0, 8'h01);
      rd(4'h0, 8'h00);
      $display("test receive full done");
      // each sensitivity level against each kind of move
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 4; l++) begin
            wr(4'h1, (s == 1) ? 8'(l << 2) : 8'(l << 4));
            for (int i = 0; i < 4; i++) begin
               cnt((s == 1) ? tt[i] : ((i == 2) ? 9'h12c : 9'h000), (s == 1) ? 8'h00 : rr[i]);
               rd(4'h0, {1'b0, l >= need[i], codes(tec, rec), 2'b00});
               wr(4'h0, 8'h40);
            end
         end
      end
      wr(4'h1, 8'h7c);
      cnt(9'h12c, 8'h00);
      chk1(irq_err, 1'b1);
      rd(4'h0, 8'h7c);
      cnt(9'h000, 8'h00);
      rd(4'h0, 8'h7c);
      check({6'h00, receiver_state}, 8'h03);
      check({6'h00, transmitter_state}, 8'h03);
      wr(4'h0, 8'h40);
      rd(4'h0, 8'h40);
      wr(4'h1, 8'h3c);
      chk1(irq_err, 1'b0);
      wr(4'h0, 8'h40);
      rd(4'h0, 8'h00);
      $display("test status change done");
      v = rnd();
      wr(4'h1, v);
      ev(1'b1, 1'b0);
      @(posedge ref_clk);
      init_request <= 1'b1;
      init_acknowledge <= 1'b1;
      cnt(9'h12c, 8'h00);
      rd(4'h1, v & 8'h3c);
      rd(4'h0, 8'h3c);
      wr(4'h1, 8'hff);
      rd(4'h1, v & 8'h3c);
      cnt(9'h000, 8'h00);
      @(posedge ref_clk);
      init_request <= 1'b0;
      init_acknowledge <= 1'b0;
      wr(4'h1, 8'h03);
      rd(4'h1, 8'h03);
      $display("test init mode done");
      repeat (3) @(posedge ref_clk);
      summarize();
   end
endmodule // testbench

`default_nettype wire
